// ### hw/iod_decoder.sv
// Operation
// - Opcode high byte 11101101 is a two-word data-to-data block move with mode flag bit 7 and operand bits 6..0.
// - Opcode high byte 11111100 is a two-word program-to-data block move with mode flag and operand.
// - Opcode high byte 01010110 is a one-word data move with mode flag bit 7 and operand bits 6..0.
// - Top nibble 1000 is port input and 1110 port output except high byte 11101101, bits 11..8 the port, bit 7 flag, bits 6..0 operand.
// - Bits 15..1 equal to 110011100000111 select serial format, bit 0 giving the format value.
// - Bits 15..1 equal to 110011100010000 clear (bit 0 low) or set (bit 0 high) transmit mode.
// - Bits 15..1 equal to 110011100011011 clear or set frame-sync mode according to bit 0.
// - Top nibble 1001 tests the bit named in bits 11..8, and high byte 01010111 tests the bit held in T.
// - Word 16'hCE04 configures the on-chip block as data and 16'hCE05 as program memory.
// - High bytes 01010000 and 01010001 load status register zero and one.
// - High bytes 01111000 and 01111001 store status register zero and one.
// - Word 16'hCE1D pops the stack to the low accumulator and 16'hCE1C pushes it.
// - High byte 01010100 pushes a data word and 01111010 pops the stack to a data word.
// - High byte 01001011 repeats by a memory count and 11001011 repeats by the count in bits 7..0.
//
// Purpose: Registered decode of the I/O, move and control instruction group
// Assumes: Fetch presents one word per cycle with word_valid
// Notes:   The word after a block-move first word is its operand, never an opcode
`timescale 1ns/100ps
`include "iod_params.svh"
`default_nettype none

module iod_decoder (
    input  wire logic              mclk,           // Processor clock
    input  wire logic              rst_n,          // Asynchronous reset, active low
    input  wire logic              word_valid,     // Fetched word present
    input  wire logic [15:0]       word,           // Fetched program word
    output logic                   dec_valid_r,    // Decoded result valid
    output iod_pkg::iod_dec_t      dec_r,          // Decoded fields
    output logic                   second_valid_r, // Block-move second word valid
    output logic [15:0]            second_word_r   // Block-move second word
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    iod_pkg::iod_state_t st_r;
    iod_pkg::iod_state_t st_nxt;
    iod_pkg::iod_dec_t   match_dec;

    iod_match u_match (
        .word (word),
        .dec  (match_dec)
    );

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        st_nxt       = st_r;
        st_nxt.valid = 1'b0;
        st_nxt.second_valid = 1'b0;
        if (word_valid) begin
            if (st_r.expect_second) begin
                // Operand word of a block move: never decoded as opcode
                st_nxt.dec           = st_r.dec;
                st_nxt.dec.op        = iod_pkg::IOD_SECOND_WORD;
                st_nxt.dec.known     = 1'b0;
                st_nxt.second_word   = word;
                st_nxt.second_valid  = 1'b1;
                st_nxt.expect_second = 1'b0;
            end else begin
                st_nxt.dec           = match_dec;
                st_nxt.valid         = 1'b1;
                st_nxt.expect_second = match_dec.two_word;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dec_valid_r    = st_r.valid;
    assign dec_r          = st_r.dec;
    assign second_valid_r = st_r.second_valid;
    assign second_word_r  = st_r.second_word;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence blk_first_s;
        word_valid && !st_r.expect_second && word[15:8] == `IOD_OP_BLK_DD;
    endsequence
    sequence second_taken_s;
        ##1 word_valid [*1] ##1 second_valid_r && !dec_valid_r;
    endsequence

    block_two_word_a: assert property (blk_first_s |-> second_taken_s or (##1 !word_valid))
        else $error("block move second word not taken");
    block_pd_a: assert property (word_valid && !st_r.expect_second && word[15:8] == `IOD_OP_BLK_PD
        |=> dec_r.op == iod_pkg::IOD_BLOCK_MOVE_PROGRAM_TO_DATA && st_r.expect_second)
        else $error("program block move not flagged two-word");
    data_move_a: assert property (word_valid && !st_r.expect_second && word[15:8] == `IOD_OP_MOVE_DATA
        |=> dec_valid_r && dec_r.op == iod_pkg::IOD_DATA_WORD_MOVE && dec_r.operand == $past(word[6:0]))
        else $error("data move decode wrong");
    port_in_a: assert property (word_valid && !st_r.expect_second && word[15:12] == `IOD_NIB_IN
        |=> dec_r.op == iod_pkg::IOD_PORT_INPUT && dec_r.select == $past(word[11:8]))
        else $error("port input decode wrong");
    format_bit_a: assert property (word_valid && !st_r.expect_second && word[15:1] == 15'h6707
        |=> dec_r.op == iod_pkg::IOD_SERIAL_FORMAT_SELECT && dec_r.format == $past(word[0]))
        else $error("format value lost");
    transmit_mode_a: assert property (word_valid && !st_r.expect_second && word == 16'hCE21
        |=> dec_r.op == iod_pkg::IOD_SET_TRANSMIT_MODE)
        else $error("transmit mode set not decoded");
    frame_sync_a: assert property (word_valid && !st_r.expect_second && word == 16'hCE36
        |=> dec_r.op == iod_pkg::IOD_CLEAR_FRAME_SYNC_MODE)
        else $error("frame sync clear not decoded");
    repeat_count_a: assert property (word_valid && !st_r.expect_second && word[15:8] == `IOD_OP_REP_IMM
        |=> dec_r.op == iod_pkg::IOD_REPEAT_IMMEDIATE_COUNT && dec_r.count == $past(word[7:0]))
        else $error("repeat count wrong");
    stack_acc_a: assert property (word_valid && !st_r.expect_second && word == 16'hCE1D
        |=> dec_r.op == iod_pkg::IOD_POP_TO_ACC)
        else $error("pop to accumulator not decoded");
    config_block_a: assert property (word_valid && !st_r.expect_second && word == 16'hCE05
        |=> dec_r.op == iod_pkg::IOD_CONFIGURE_BLOCK_AS_PROGRAM)
        else $error("configure program not decoded");

endmodule

`default_nettype wire

// ### hw/iod_match.sv
// Purpose: Pure combinational match of one program word
// Assumes: Word is stable while decoded
// Notes:   No state; the top registers the result
`timescale 1ns/100ps
`include "iod_params.svh"
`default_nettype none

module iod_match (
    input  wire logic [15:0]  word,    // Program word
    output iod_pkg::iod_dec_t dec      // Decoded fields
);

    logic [7:0] hi;
    logic [7:0] lo;
    logic [3:0] nib;

    assign hi  = word[`IOD_HI_MSB:`IOD_HI_LSB];
    assign lo  = word[7:0];
    assign nib = word[15:12];

    always_comb begin
        dec           = '0;
        dec.op        = iod_pkg::IOD_NONE;
        dec.addr_flag = word[`IOD_ADDR_FLAG_BIT];
        dec.operand   = word[6:0];
        dec.select    = word[`IOD_PORT_MSB:`IOD_PORT_LSB];
        dec.count     = lo;
        dec.format    = word[0];
        if (nib == `IOD_NIB_IN) begin
            dec.op = iod_pkg::IOD_PORT_INPUT;
        end else if (nib == `IOD_NIB_OUT && hi != `IOD_OP_BLK_DD) begin
            dec.op = iod_pkg::IOD_PORT_OUTPUT;
        end else if (nib == `IOD_NIB_BIT) begin
            dec.op = iod_pkg::IOD_TEST_BIT;
        end else begin
            unique case (hi)
                `IOD_OP_BLK_DD: begin
                    dec.op       = iod_pkg::IOD_BLOCK_MOVE_DATA_TO_DATA;
                    dec.two_word = 1'b1;
                end
                `IOD_OP_BLK_PD: begin
                    dec.op       = iod_pkg::IOD_BLOCK_MOVE_PROGRAM_TO_DATA;
                    dec.two_word = 1'b1;
                end
                `IOD_OP_MOVE_DATA: dec.op = iod_pkg::IOD_DATA_WORD_MOVE;
                `IOD_OP_BIT_BY_T:  dec.op = iod_pkg::IOD_TEST_BIT_BY_T_REGISTER;
                `IOD_OP_LOAD_S0:   dec.op = iod_pkg::IOD_LOAD_STATUS_ZERO;
                `IOD_OP_LOAD_S1:   dec.op = iod_pkg::IOD_LOAD_STATUS_ONE;
                `IOD_OP_STORE_S0:  dec.op = iod_pkg::IOD_STORE_STATUS_ZERO;
                `IOD_OP_STORE_S1:  dec.op = iod_pkg::IOD_STORE_STATUS_ONE;
                `IOD_OP_PUSH_DATA: dec.op = iod_pkg::IOD_PUSH_DATA_WORD;
                `IOD_OP_POP_DATA:  dec.op = iod_pkg::IOD_POP_TO_DATA_WORD;
                `IOD_OP_REP_MEM:   dec.op = iod_pkg::IOD_REPEAT_FROM_MEMORY;
                `IOD_OP_REP_IMM:   dec.op = iod_pkg::IOD_REPEAT_IMMEDIATE_COUNT;
                `IOD_OP_CTRL: begin
                    unique case (lo)
                        `IOD_LO_FMT0, `IOD_LO_FMT1:
                            dec.op = iod_pkg::IOD_SERIAL_FORMAT_SELECT;
                        `IOD_LO_TX_CLR: dec.op = iod_pkg::IOD_CLEAR_TRANSMIT_MODE;
                        `IOD_LO_TX_SET: dec.op = iod_pkg::IOD_SET_TRANSMIT_MODE;
                        `IOD_LO_FS_CLR: dec.op = iod_pkg::IOD_CLEAR_FRAME_SYNC_MODE;
                        `IOD_LO_FS_SET: dec.op = iod_pkg::IOD_SET_FRAME_SYNC_MODE;
                        `IOD_LO_CFG_DATA: dec.op = iod_pkg::IOD_CONFIGURE_BLOCK_AS_DATA;
                        `IOD_LO_CFG_PROG: dec.op = iod_pkg::IOD_CONFIGURE_BLOCK_AS_PROGRAM;
                        `IOD_LO_POP:  dec.op = iod_pkg::IOD_POP_TO_ACC;
                        `IOD_LO_PUSH: dec.op = iod_pkg::IOD_PUSH_FROM_ACC;
                        `IOD_LO_EINT: dec.op = iod_pkg::IOD_ENABLE_INTERRUPT;
                        `IOD_LO_DINT: dec.op = iod_pkg::IOD_DISABLE_INTERRUPT;
                        `IOD_LO_IDLE: dec.op = iod_pkg::IOD_IDLE;
                        `IOD_LO_TRAP: dec.op = iod_pkg::IOD_TRAP;
                        `IOD_LO_RC:   dec.op = iod_pkg::IOD_CLEAR_CARRY;
                        `IOD_LO_SC:   dec.op = iod_pkg::IOD_SET_CARRY;
                        `IOD_LO_RHM:  dec.op = iod_pkg::IOD_CLEAR_HOLD_MODE;
                        `IOD_LO_SHM:  dec.op = iod_pkg::IOD_SET_HOLD_MODE;
                        `IOD_LO_ROVM: dec.op = iod_pkg::IOD_CLEAR_OVERFLOW_MODE;
                        `IOD_LO_SOVM: dec.op = iod_pkg::IOD_SET_OVERFLOW_MODE;
                        `IOD_LO_RSXM: dec.op = iod_pkg::IOD_CLEAR_SIGN_EXT_MODE;
                        `IOD_LO_SSXM: dec.op = iod_pkg::IOD_SET_SIGN_EXT_MODE;
                        `IOD_LO_RTC:  dec.op = iod_pkg::IOD_CLEAR_TEST_FLAG;
                        `IOD_LO_STC:  dec.op = iod_pkg::IOD_SET_TEST_FLAG;
                        `IOD_LO_RXF:  dec.op = iod_pkg::IOD_CLEAR_EXT_FLAG;
                        `IOD_LO_SXF:  dec.op = iod_pkg::IOD_SET_EXT_FLAG;
                        default:      dec.op = iod_pkg::IOD_NONE;
                    endcase
                end
                default: dec.op = iod_pkg::IOD_NONE;
            endcase
        end
        dec.known = (dec.op != iod_pkg::IOD_NONE);
    end

endmodule

`default_nettype wire

// ### hw/iod_params.svh
// Purpose: Opcode patterns and field positions for the I/O and control decoder
// Assumes: 16-bit program words
// Notes:   Patterns are matched on the top nibble, the upper byte or the whole word
`ifndef IOD_PARAMS_SVH
`define IOD_PARAMS_SVH

// ----------------------------------------
// Field positions
// ----------------------------------------
`define IOD_ADDR_FLAG_BIT    7
`define IOD_HI_MSB           15
`define IOD_HI_LSB           8
`define IOD_PORT_MSB         11
`define IOD_PORT_LSB         8

// ----------------------------------------
// Upper-byte patterns
// ----------------------------------------
`define IOD_OP_BLK_DD        8'hED
`define IOD_OP_BLK_PD        8'hFC
`define IOD_OP_MOVE_DATA     8'h56
`define IOD_OP_BIT_BY_T      8'h57
`define IOD_OP_LOAD_S0       8'h50
`define IOD_OP_LOAD_S1       8'h51
`define IOD_OP_STORE_S0      8'h78
`define IOD_OP_STORE_S1      8'h79
`define IOD_OP_PUSH_DATA     8'h54
`define IOD_OP_POP_DATA      8'h7A
`define IOD_OP_REP_MEM       8'h4B
`define IOD_OP_REP_IMM       8'hCB
`define IOD_OP_CTRL          8'hCE

// ----------------------------------------
// Top-nibble patterns
// ----------------------------------------
`define IOD_NIB_IN           4'h8
`define IOD_NIB_OUT          4'hE
`define IOD_NIB_BIT          4'h9

// ----------------------------------------
// Control-group low bytes (upper byte 8'hCE)
// ----------------------------------------
`define IOD_LO_EINT          8'h00
`define IOD_LO_DINT          8'h01
`define IOD_LO_ROVM          8'h02
`define IOD_LO_SOVM          8'h03
`define IOD_LO_CFG_DATA      8'h04
`define IOD_LO_CFG_PROG      8'h05
`define IOD_LO_RSXM          8'h06
`define IOD_LO_SSXM          8'h07
`define IOD_LO_RXF           8'h0C
`define IOD_LO_SXF           8'h0D
`define IOD_LO_FMT0          8'h0E
`define IOD_LO_FMT1          8'h0F
`define IOD_LO_TX_CLR        8'h20
`define IOD_LO_TX_SET        8'h21
`define IOD_LO_PUSH          8'h1C
`define IOD_LO_POP           8'h1D
`define IOD_LO_TRAP          8'h1E
`define IOD_LO_IDLE          8'h1F
`define IOD_LO_RC            8'h30
`define IOD_LO_SC            8'h31
`define IOD_LO_RTC           8'h32
`define IOD_LO_STC           8'h33
`define IOD_LO_FS_CLR        8'h36
`define IOD_LO_FS_SET        8'h37
`define IOD_LO_RHM           8'h38
`define IOD_LO_SHM           8'h39

// ----------------------------------------
// Reset values
// ----------------------------------------
`define IOD_RST_WORD         16'h0000

`endif

// ### hw/iod_pkg.sv
// Purpose: Types shared by the I/O and control decoder files
// Assumes: iod_params.svh holds the opcode pattern and field position macros
// Notes:   Operation codes are one enum, operand fields one struct
package iod_pkg;

    typedef enum logic [5:0] {
        IOD_NONE,
        IOD_BLOCK_MOVE_DATA_TO_DATA,
        IOD_BLOCK_MOVE_PROGRAM_TO_DATA,
        IOD_DATA_WORD_MOVE,
        IOD_PORT_INPUT,
        IOD_PORT_OUTPUT,
        IOD_SERIAL_FORMAT_SELECT,
        IOD_CLEAR_TRANSMIT_MODE,
        IOD_SET_TRANSMIT_MODE,
        IOD_CLEAR_FRAME_SYNC_MODE,
        IOD_SET_FRAME_SYNC_MODE,
        IOD_TEST_BIT,
        IOD_TEST_BIT_BY_T_REGISTER,
        IOD_CONFIGURE_BLOCK_AS_DATA,
        IOD_CONFIGURE_BLOCK_AS_PROGRAM,
        IOD_LOAD_STATUS_ZERO,
        IOD_LOAD_STATUS_ONE,
        IOD_STORE_STATUS_ZERO,
        IOD_STORE_STATUS_ONE,
        IOD_POP_TO_ACC,
        IOD_PUSH_FROM_ACC,
        IOD_PUSH_DATA_WORD,
        IOD_POP_TO_DATA_WORD,
        IOD_REPEAT_FROM_MEMORY,
        IOD_REPEAT_IMMEDIATE_COUNT,
        IOD_ENABLE_INTERRUPT,
        IOD_DISABLE_INTERRUPT,
        IOD_IDLE,
        IOD_TRAP,
        IOD_CLEAR_CARRY,
        IOD_SET_CARRY,
        IOD_CLEAR_HOLD_MODE,
        IOD_SET_HOLD_MODE,
        IOD_CLEAR_OVERFLOW_MODE,
        IOD_SET_OVERFLOW_MODE,
        IOD_CLEAR_SIGN_EXT_MODE,
        IOD_SET_SIGN_EXT_MODE,
        IOD_CLEAR_TEST_FLAG,
        IOD_SET_TEST_FLAG,
        IOD_CLEAR_EXT_FLAG,
        IOD_SET_EXT_FLAG,
        IOD_SECOND_WORD
    } iod_op_t;

    typedef struct packed {
        iod_op_t     op;
        logic        known;
        logic        two_word;
        logic        addr_flag;
        logic [6:0]  operand;
        logic [3:0]  select;
        logic [7:0]  count;
        logic        format;
    } iod_dec_t;

    typedef struct packed {
        iod_dec_t    dec;
        logic        valid;
        logic        expect_second;
        logic        second_valid;
        logic [15:0] second_word;
    } iod_state_t;

endpackage

// ### tb/dsp_io_control_opcode_decoder_tb_top.sv
// Purpose: Self-checking bench for the I/O, move and control decoder
// Assumes: Result is read one cycle after the word is taken
// Notes:   Expected fields come from the opcode bit patterns, not from the design
`timescale 1ns/100ps
`default_nettype none

module dsp_io_control_opcode_decoder_tb_top;
    logic              mclk = 1'b0;
    logic              rst_n;
    logic              word_valid;
    logic [15:0]       word;
    logic              dec_valid_r;
    iod_pkg::iod_dec_t dec_r;
    logic              second_valid_r;
    logic [15:0]       second_word_r;
    int                mismatches = 0;
    int                check_count = 0;
    logic [7:0]        mem_hi [9] = '{8'h56, 8'h57, 8'h50, 8'h51, 8'h78, 8'h79, 8'h54, 8'h7a, 8'h4b};
    iod_pkg::iod_op_t  mem_op [9] = '{iod_pkg::IOD_DATA_WORD_MOVE, iod_pkg::IOD_TEST_BIT_BY_T_REGISTER,
        iod_pkg::IOD_LOAD_STATUS_ZERO, iod_pkg::IOD_LOAD_STATUS_ONE, iod_pkg::IOD_STORE_STATUS_ZERO,
        iod_pkg::IOD_STORE_STATUS_ONE, iod_pkg::IOD_PUSH_DATA_WORD, iod_pkg::IOD_POP_TO_DATA_WORD,
        iod_pkg::IOD_REPEAT_FROM_MEMORY};
    logic [7:0]        ctl_lo [26] = '{8'h04, 8'h05, 8'h0e, 8'h0f, 8'h20, 8'h21, 8'h36, 8'h37, 8'h1d, 8'h1c,
        8'h00, 8'h01, 8'h1f, 8'h1e, 8'h30, 8'h31, 8'h38, 8'h39, 8'h02, 8'h03, 8'h06, 8'h07, 8'h32, 8'h33,
        8'h0c, 8'h0d};
    iod_pkg::iod_op_t  ctl_op [26] = '{iod_pkg::IOD_CONFIGURE_BLOCK_AS_DATA, iod_pkg::IOD_CONFIGURE_BLOCK_AS_PROGRAM,
        iod_pkg::IOD_SERIAL_FORMAT_SELECT, iod_pkg::IOD_SERIAL_FORMAT_SELECT, iod_pkg::IOD_CLEAR_TRANSMIT_MODE,
        iod_pkg::IOD_SET_TRANSMIT_MODE, iod_pkg::IOD_CLEAR_FRAME_SYNC_MODE, iod_pkg::IOD_SET_FRAME_SYNC_MODE,
        iod_pkg::IOD_POP_TO_ACC, iod_pkg::IOD_PUSH_FROM_ACC, iod_pkg::IOD_ENABLE_INTERRUPT,
        iod_pkg::IOD_DISABLE_INTERRUPT, iod_pkg::IOD_IDLE, iod_pkg::IOD_TRAP, iod_pkg::IOD_CLEAR_CARRY,
        iod_pkg::IOD_SET_CARRY, iod_pkg::IOD_CLEAR_HOLD_MODE, iod_pkg::IOD_SET_HOLD_MODE,
        iod_pkg::IOD_CLEAR_OVERFLOW_MODE, iod_pkg::IOD_SET_OVERFLOW_MODE, iod_pkg::IOD_CLEAR_SIGN_EXT_MODE,
        iod_pkg::IOD_SET_SIGN_EXT_MODE, iod_pkg::IOD_CLEAR_TEST_FLAG, iod_pkg::IOD_SET_TEST_FLAG,
        iod_pkg::IOD_CLEAR_EXT_FLAG, iod_pkg::IOD_SET_EXT_FLAG};

    iod_fetch_model fetch (.mclk(mclk), .word_valid(word_valid), .word(word));

    iod_decoder dut (
        .mclk           (mclk),
        .rst_n          (rst_n),
        .word_valid     (word_valid),
        .word           (word),
        .dec_valid_r    (dec_valid_r),
        .dec_r          (dec_r),
        .second_valid_r (second_valid_r),
        .second_word_r  (second_word_r)
    );

    always #2.5 mclk = ~mclk;

    // ----------------------------------------
    // Compare and report
    // ----------------------------------------
    task automatic chk_val(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_op(input string name, input iod_pkg::iod_op_t exp, input iod_pkg::iod_op_t got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // One word, then idle; memory forms also carry flag and operand
    task automatic run_word(input logic [15:0] w, input iod_pkg::iod_op_t op, input logic mem);
        fetch.issue(w);
        fetch.idle();
        #1;
        chk_val("dec_valid", 16'h0001, {15'h0000, dec_valid_r});
        chk_op("op", op, dec_r.op);
        chk_val("known", 16'h0001, {15'h0000, dec_r.known});
        chk_val("two_word", 16'h0000, {15'h0000, dec_r.two_word});
        if (mem) begin
            chk_val("addr_flag", {15'h0000, w[7]}, {15'h0000, dec_r.addr_flag});
            chk_val("operand", {9'h000, w[6:0]}, {9'h000, dec_r.operand});
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Second word looks like an opcode on purpose: it must pass as data
    task automatic t_block(input logic [15:0] w1, input logic [15:0] w2, input iod_pkg::iod_op_t op,
                           input int gap);
        fetch.issue(w1);
        repeat (gap) fetch.idle();
        fetch.issue(w2);
        if (gap == 0) begin
            #1;
            chk_op("blk_op", op, dec_r.op);
            chk_val("blk_two", 16'h0001, {15'h0000, dec_r.two_word});
            chk_val("blk_flag", {15'h0000, w1[7]}, {15'h0000, dec_r.addr_flag});
            chk_val("blk_operand", {9'h000, w1[6:0]}, {9'h000, dec_r.operand});
        end
        fetch.idle();
        #1;
        chk_val("second_valid", 16'h0001, {15'h0000, second_valid_r});
        chk_val("second_word", w2, second_word_r);
        chk_val("dec_valid_on_second", 16'h0000, {15'h0000, dec_valid_r});
        chk_op("second_op", iod_pkg::IOD_SECOND_WORD, dec_r.op);
    endtask

    task automatic t_ports();
        for (int p = 0; p < 16; p++) begin
            run_word({4'h8, p[3:0], p[0], p[6:0]}, iod_pkg::IOD_PORT_INPUT, 1'b1);
            chk_val("in_select", {12'h000, p[3:0]}, {12'h000, dec_r.select});
            run_word({4'h9, p[3:0], 8'h5a}, iod_pkg::IOD_TEST_BIT, 1'b1);
            chk_val("bit_select", {12'h000, p[3:0]}, {12'h000, dec_r.select});
            if (p != 13) begin
                run_word({4'he, p[3:0], ~p[0], ~p[6:0]}, iod_pkg::IOD_PORT_OUTPUT, 1'b1);
                chk_val("out_select", {12'h000, p[3:0]}, {12'h000, dec_r.select});
            end
        end
    endtask

    task automatic t_ctrl();
        for (int i = 0; i < 26; i++) begin
            run_word({8'hce, ctl_lo[i]}, ctl_op[i], 1'b0);
            if (ctl_op[i] == iod_pkg::IOD_SERIAL_FORMAT_SELECT)
                chk_val("format", {15'h0000, ctl_lo[i][0]}, {15'h0000, dec_r.format});
        end
    endtask

    // Result pulses for one cycle, fields hold afterwards
    task automatic t_back_to_back();
        fetch.issue(16'hce20);
        fetch.issue(16'hce21);
        #1;
        chk_op("b2b_first", iod_pkg::IOD_CLEAR_TRANSMIT_MODE, dec_r.op);
        fetch.idle();
        #1;
        chk_val("b2b_valid", 16'h0001, {15'h0000, dec_valid_r});
        chk_op("b2b_second", iod_pkg::IOD_SET_TRANSMIT_MODE, dec_r.op);
        fetch.idle();
        #1;
        chk_val("b2b_drop", 16'h0000, {15'h0000, dec_valid_r});
        chk_op("b2b_hold", iod_pkg::IOD_SET_TRANSMIT_MODE, dec_r.op);
        fetch.issue(16'hceff);
        fetch.idle();
        #1;
        chk_val("unknown_valid", 16'h0001, {15'h0000, dec_valid_r});
        chk_val("unknown_known", 16'h0000, {15'h0000, dec_r.known});
        chk_op("unknown_op", iod_pkg::IOD_NONE, dec_r.op);
    endtask

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        rst_n = 1'b0;
        repeat (20) @(posedge mclk);
        #1;
        chk_val("reset_valid", 16'h0000, {15'h0000, dec_valid_r});
        chk_op("reset_op", iod_pkg::IOD_NONE, dec_r.op);
        @(posedge mclk);
        rst_n <= 1'b1;
        t_block(16'hed85, 16'hed00, iod_pkg::IOD_BLOCK_MOVE_DATA_TO_DATA, 0);
        t_block(16'hfc2a, 16'hce1c, iod_pkg::IOD_BLOCK_MOVE_PROGRAM_TO_DATA, 0);
        t_block(16'hfcff, 16'h5600, iod_pkg::IOD_BLOCK_MOVE_PROGRAM_TO_DATA, 2);
        for (int i = 0; i < 9; i++) begin
            run_word({mem_hi[i], i[0], i[6:0] ^ 7'h55}, mem_op[i], 1'b1);
        end
        t_ports();
        run_word(16'hcb00, iod_pkg::IOD_REPEAT_IMMEDIATE_COUNT, 1'b0);
        chk_val("count_low", 16'h0000, {8'h00, dec_r.count});
        run_word(16'hcbff, iod_pkg::IOD_REPEAT_IMMEDIATE_COUNT, 1'b0);
        chk_val("count_high", 16'h00ff, {8'h00, dec_r.count});
        t_ctrl();
        t_back_to_back();
        test_done();
    end

    // About 210 cycles are needed; the limit leaves ample margin
    initial begin
        #100000;
        mismatches++;
        $display("ERROR watchdog expected finish seen timeout");
        test_done();
    end
endmodule
`default_nettype wire

// ### tb/iod_fetch_model.sv
// Purpose: Fetch-unit model that presents program words to the decoder
// Assumes: One word per rising edge; inputs change by non-blocking assignment
// Notes:   An idle bus shows the inverse of the bus word, so a second idle in a row shows the issued word again
`timescale 1ns/100ps
`default_nettype none

module iod_fetch_model (
    input  wire logic        mclk,       // Processor clock
    output var  logic        word_valid, // Word present
    output var  logic [15:0] word        // Program word
);
    initial begin
        word_valid = 1'b0;
        word       = 16'h0000;
    end

    // ----------------------------------------
    // Word presentation
    // ----------------------------------------
    // Back-to-back calls present one word per cycle with no gap
    task automatic issue(input logic [15:0] w);
        @(posedge mclk);
        word_valid <= 1'b1;
        word       <= w;
    endtask

    // Inverting the released word keeps the decoder from seeing a valid-looking repeat
    task automatic idle();
        @(posedge mclk);
        word_valid <= 1'b0;
        word       <= ~word;
    endtask
endmodule
`default_nettype wire
